/* File: hdl/sarc_defines.svh */
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// special function register addresses
`define SARC_ADDR_CONFIG     8'hBC
`define SARC_ADDR_RES_LOW    8'hBD
`define SARC_ADDR_RES_HIGH   8'hBE
`define SARC_ADDR_CONTROL    8'hE8

// reset values
`define SARC_CONFIG_RST      8'hF8
`define SARC_CONTROL_RST     8'h00
`define SARC_RESULT_RST      8'h00

// converter_control bit positions
`define SARC_CTL_EN_BIT      7
`define SARC_CTL_TM_BIT      6
`define SARC_CTL_INT_BIT     5
`define SARC_CTL_BUSY_BIT    4

// conversion lengths in conversion clocks
`define SARC_LEN_TEN         5'h0E
`define SARC_LEN_EIGHT       5'h0C
`define SARC_TRACK_DELAY     5'h03
`define SARC_SAMPLE_TICKS    5'h04

// top trial bit and last resolved bit per mode
`define SARC_MSB_TRIAL       10'h200
`define SARC_LAST_TEN        10'h001
`define SARC_LAST_EIGHT      10'h004

`endif

/* File: hdl/sarc_pkg.sv */
package sarc_pkg;

  typedef enum logic [2:0] {
    SARC_SRC_SOFT   = 3'h0,
    SARC_SRC_TMR0   = 3'h1,
    SARC_SRC_TMR2   = 3'h2,
    SARC_SRC_TMR1   = 3'h3,
    SARC_SRC_PIN    = 3'h4,
    SARC_SRC_TMR3   = 3'h5
  } sarc_src_t;

  // gray codes along idle -> delay -> convert
  typedef enum logic [1:0] {
    SARC_ST_IDLE  = 2'h0,
    SARC_ST_DELAY = 2'h1,
    SARC_ST_CONV  = 2'h3
  } sarc_state_t;

  typedef struct packed {
    logic [4:0] clk_div;
    logic       justify;
    logic       eight_bit;
    logic       gain;
  } sarc_cfg_t;

  typedef struct packed {
    logic       enable;
    logic       tracking_delay;
    logic       complete;
    logic       busy;
    logic       window_flag;
    logic [2:0] start_mode;
  } sarc_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sarc_result_t;

  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_low_ovf;
    logic t2_high_ovf;
    logic t2_split;
    logic t3_low_ovf;
    logic t3_high_ovf;
    logic t3_split;
  } sarc_timers_t;

endpackage : sarc_pkg

/* File: hdl/sarc_conv_ctrl.sv */
`timescale 1ns/100ps
`include "sarc_defines.svh"
// How it works
// - result is an unsigned 10-bit code, zero up to reference times 1023/1024.
// - justify 0 puts code in low bits, justify 1 in top bits.
// - result bits not carrying code bits read as zero.
// - eight-bit mode converts 8 MSBs, result lands in the high byte.
// - eight-bit mode ignores the justify select.
// - eight-bit conversion takes two conversion clocks fewer than ten-bit.
// - conversion clock is the system clock divided by the divider field plus one.
// - divider field equals system clock over conversion clock, minus one.
// - six trigger sources chosen by the start-mode field.
// - in software mode writing 1 to busy launches a conversion.
// - busy stays 1 during conversion and clears when it ends.
// - busy falling sets the conversion-complete flag and interrupt request.
// - result bytes hold valid data whenever the complete flag is 1.
// - timers 2 and 3 use low overflows in 8-bit, high in 16-bit mode.
// - tracking delay set postpones conversion by three conversion clocks.
// - tracking delay clear starts converting straight after the trigger.
// - internal triggers: track whenever not converting.
// - pin trigger: track if delay set, or delay clear and pin low.
// - eight-bit ends at conversion clock 12, or 15 with delay.
// - gain bit selects gain 0.5 when 0 and 1 when 1.
module sarc_conv_ctrl
  import sarc_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // special function register port
  input  wire logic [7:0]   sfr_addr_i,
  input  wire logic         sfr_wr_i,
  input  wire logic [7:0]   sfr_wdata_i,
  output logic      [7:0]   sfr_rdata_o,
  // trigger sources
  input  wire sarc_timers_t timers_i,
  input  wire logic         external_start_pin_i,
  // analog converter side
  input  wire logic         cmp_i,
  output logic      [9:0]   sar_dac_o,
  output logic              track_o,
  output logic              gain_select_o,
  output logic              enable_o,
  output logic              irq_o
);

  if (DIV_W != 5) begin : g_div_check
    $error("sarc_conv_ctrl: divider field is 5 bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // start pin synchroniser and edge detect

  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_last_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= external_start_pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and conversion state

  sarc_cfg_t        cfg_reg,     cfg_next;
  sarc_ctrl_t       ctl_reg,     ctl_next;
  sarc_result_t     res_reg,     res_next;
  sarc_state_t      state_reg,   state_next;
  logic [DIV_W-1:0] div_reg,     div_next;
  logic [4:0]       ticks_reg,   ticks_next;
  logic [9:0]       trial_reg,   trial_next;
  logic [9:0]       mask_reg,    mask_next;
  logic             eight_reg,   eight_next;
  logic             delay_reg,   delay_next;
  logic             just_reg,    just_next;
  logic             track_reg,   track_next;
  logic [7:0]       rdata_reg,   rdata_next;

  logic       tick;
  logic       trig;
  logic       start;
  logic       resolve;
  logic       last_bit;
  logic       ctl_wr;
  logic       done;
  logic [4:0] delay_ticks;
  logic [9:0] code;

  always_comb begin
    cfg_next   = cfg_reg;
    ctl_next   = ctl_reg;
    res_next   = res_reg;
    state_next = state_reg;
    div_next   = div_reg;
    ticks_next = ticks_reg;
    trial_next = trial_reg;
    mask_next  = mask_reg;
    eight_next = eight_reg;
    delay_next = delay_reg;
    just_next  = just_reg;
    ctl_wr     = sfr_wr_i && (sfr_addr_i == `SARC_ADDR_CONTROL);

    // conversion clock tick every divider+1 system clocks
    // divider field value is the ratio minus one
    tick     = (div_reg == cfg_reg.clk_div);
    div_next = (tick || state_reg == SARC_ST_IDLE) ? '0 : div_reg + 1'b1;

    // timer 2/3 overflow width follows the timer mode
    case (sarc_src_t'(ctl_reg.start_mode))
      SARC_SRC_SOFT: trig = ctl_wr && sfr_wdata_i[`SARC_CTL_BUSY_BIT];
      SARC_SRC_TMR0: trig = timers_i.t0_ovf;
      SARC_SRC_TMR2: trig = timers_i.t2_split ? timers_i.t2_low_ovf : timers_i.t2_high_ovf;
      SARC_SRC_TMR1: trig = timers_i.t1_ovf;
      SARC_SRC_PIN:  trig = pin_sync_reg && !pin_last_reg;
      SARC_SRC_TMR3: trig = timers_i.t3_split ? timers_i.t3_low_ovf : timers_i.t3_high_ovf;
      default:       trig = 1'b0;
    endcase
    start = trig && ctl_reg.enable && (state_reg == SARC_ST_IDLE);

    delay_ticks = delay_reg ? `SARC_TRACK_DELAY : 5'h00;
    resolve     = tick && (state_reg == SARC_ST_CONV)
                  && (ticks_reg + 5'h01 > delay_ticks + `SARC_SAMPLE_TICKS);
    last_bit    = (mask_reg == (eight_reg ? `SARC_LAST_EIGHT : `SARC_LAST_TEN));
    done        = resolve && last_bit;

    // register writes; busy is owned by hardware
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `SARC_ADDR_CONFIG:   cfg_next = sarc_cfg_t'(sfr_wdata_i);
        `SARC_ADDR_RES_LOW:  res_next.low  = sfr_wdata_i;
        `SARC_ADDR_RES_HIGH: res_next.high = sfr_wdata_i;
        `SARC_ADDR_CONTROL: begin
          ctl_next      = sarc_ctrl_t'(sfr_wdata_i);
          ctl_next.busy = ctl_reg.busy;
        end
        default: ;
      endcase
    end

    case (state_reg)
      SARC_ST_IDLE: begin
        if (start) begin
          ctl_next.busy = 1'b1;
          ticks_next    = '0;
          eight_next    = cfg_reg.eight_bit;
          just_next     = cfg_reg.justify;
          delay_next    = ctl_reg.tracking_delay;
          trial_next    = `SARC_MSB_TRIAL;
          mask_next     = `SARC_MSB_TRIAL;
          // delayed start tracks for three conversion clocks
          // no delay goes straight to converting
          state_next    = ctl_reg.tracking_delay ? SARC_ST_DELAY : SARC_ST_CONV;
        end
      end
      SARC_ST_DELAY: begin
        if (tick) begin
          ticks_next = ticks_reg + 5'h01;
          if (ticks_reg + 5'h01 == `SARC_TRACK_DELAY) state_next = SARC_ST_CONV;
        end
      end
      SARC_ST_CONV: begin
        if (tick) ticks_next = ticks_reg + 5'h01;
        if (resolve) begin
          // binary search toward the unsigned code
          trial_next = cmp_i ? trial_reg : (trial_reg & ~mask_reg);
          mask_next  = mask_reg >> 1;
          if (!last_bit) trial_next = trial_next | (mask_reg >> 1);
        end
        // eight-bit ends at clock 12, 15 with delay
        // ten-bit ends at clock 14, 17 with delay
        // two clocks fewer in eight-bit mode
        if (done) begin
          ctl_next.busy = 1'b0;
          state_next    = SARC_ST_IDLE;
        end
      end
      default: state_next = SARC_ST_IDLE;
    endcase

    code = cmp_i ? trial_reg : (trial_reg & ~mask_reg);
    if (done) begin
      if (eight_reg) begin
        res_next.high = code[9:2];
        res_next.low  = 8'h00;
      end else if (just_reg) begin
        res_next.high = code[9:2];
        res_next.low  = {code[1:0], 6'h00};
      end else begin
        res_next.high = {6'h00, code[9:8]};
        res_next.low  = code[7:0];
      end
      // busy falling sets complete flag, set wins over clear
      // result written in the same edge as the flag
      ctl_next.complete = 1'b1;
    end

    // internal sources track whenever not converting
    // pin source tracks if delay set, or delay clear and pin low
    if (state_next == SARC_ST_CONV) begin
      track_next = 1'b0;
    end else if (ctl_next.start_mode == SARC_SRC_PIN && !ctl_next.tracking_delay) begin
      track_next = (state_next == SARC_ST_DELAY) || !pin_sync_reg;
    end else begin
      track_next = 1'b1;
    end

    case (sfr_addr_i)
      `SARC_ADDR_CONFIG:   rdata_next = cfg_reg;
      `SARC_ADDR_RES_LOW:  rdata_next = res_reg.low;
      `SARC_ADDR_RES_HIGH: rdata_next = res_reg.high;
      `SARC_ADDR_CONTROL:  rdata_next = ctl_reg;
      default:             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_reg   <= sarc_cfg_t'(`SARC_CONFIG_RST);
      ctl_reg   <= sarc_ctrl_t'(`SARC_CONTROL_RST);
      res_reg   <= {`SARC_RESULT_RST, `SARC_RESULT_RST};
      state_reg <= SARC_ST_IDLE;
      div_reg   <= '0;
      ticks_reg <= '0;
      trial_reg <= '0;
      mask_reg  <= '0;
      eight_reg <= 1'b0;
      delay_reg <= 1'b0;
      just_reg  <= 1'b0;
      track_reg <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg   <= cfg_next;
      ctl_reg   <= ctl_next;
      res_reg   <= res_next;
      state_reg <= state_next;
      div_reg   <= div_next;
      ticks_reg <= ticks_next;
      trial_reg <= trial_next;
      mask_reg  <= mask_next;
      eight_reg <= eight_next;
      delay_reg <= delay_next;
      just_reg  <= just_next;
      track_reg <= track_next;
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign sar_dac_o   = trial_reg;
  assign track_o     = track_reg;
  // gain bit drives the front end gain select
  assign gain_select_o = cfg_reg.gain;
  assign enable_o    = ctl_reg.enable;
  assign irq_o       = ctl_reg.complete;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [9:0] busy_cyc_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_cyc_reg <= '0;
    end else begin
      busy_cyc_reg <= ctl_reg.busy ? busy_cyc_reg + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_busy_fall_flag: assert property ($fell(ctl_reg.busy) |-> ctl_reg.complete)
    else $error("complete flag not set when busy fell");
  a_conv_length: assert property (done && $stable(cfg_reg.clk_div) |->
      busy_cyc_reg + 10'h001 == 10'((cfg_reg.clk_div + 1) *
      ((eight_reg ? 12 : 14) + (delay_reg ? 3 : 0))))
    else $error("conversion length wrong");
  a_right_zeros: assert property (done && !eight_reg && !just_reg |=>
      res_reg.high[7:2] == 6'h00)
    else $error("right justified high bits not zero");
  a_left_zeros: assert property (done && !eight_reg && just_reg |=>
      res_reg.low[5:0] == 6'h00)
    else $error("left justified low bits not zero");
  a_eight_low_zero: assert property (done && eight_reg |=> res_reg.low == 8'h00)
    else $error("eight-bit low byte not zero");
  a_soft_start: assert property (state_reg == SARC_ST_IDLE && ctl_reg.enable &&
      ctl_reg.start_mode == 3'h0 && ctl_wr && sfr_wdata_i[4] |=> ctl_reg.busy)
    else $error("software start not taken");
  a_pin_start: assert property (state_reg == SARC_ST_IDLE && ctl_reg.enable &&
      ctl_reg.start_mode == 3'h4 && $rose(pin_sync_reg) |=> ctl_reg.busy)
    else $error("pin edge not taken");
  a_delay_tracks: assert property (state_reg == SARC_ST_DELAY |-> track_o)
    else $error("not tracking during delay");
  a_conv_holds: assert property (state_reg == SARC_ST_CONV |-> !track_o)
    else $error("tracking while converting");
  a_busy_held: assert property (state_reg != SARC_ST_IDLE |-> ctl_reg.busy)
    else $error("busy low during conversion");

endmodule : sarc_conv_ctrl

/* File: verif/sarc_analog_model.sv */
`timescale 1ns/100ps
module sarc_analog_model (
  // trial code from the converter
  input  wire logic [9:0] sar_dac_i,
  // sampled input expressed as a code
  input  wire logic [9:0] code_i,
  // comparator decision
  output logic            cmp_o
);
  assign cmp_o = (code_i >= sar_dac_i);
endmodule : sarc_analog_model

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`include "sarc_defines.svh"
module testbench;
  import sarc_pkg::*;
  logic         clk_i;
  logic         resetn_i;
  logic [7:0]   sfr_addr_i;
  logic         sfr_wr_i;
  logic [7:0]   sfr_wdata_i;
  logic [7:0]   sfr_rdata_o;
  sarc_timers_t tmr;
  logic         pin_i;
  logic         cmp_i;
  logic [9:0]   sar_dac_o;
  logic         track_o;
  logic         gain_select_o;
  logic         enable_o;
  logic         irq_o;
  logic [9:0]   code;
  int           err_total;
  int           n_tests;
  int           cyc;
  // per case: input code, config, control, result, cycles
  logic [9:0]   tcode [8] = '{10'h3FF, 10'h3FF, 10'h200, 10'h100, 10'h2AB, 10'h155, 10'h000, 10'h1FF};
  logic [7:0]   tcfg  [8] = '{8'h01, 8'h04, 8'h0C, 8'h11, 8'h06, 8'h02, 8'h1C, 8'h0A};
  logic [7:0]   tctl  [8] = '{8'h80, 8'h80, 8'hC0, 8'h80, 8'h80, 8'hC0, 8'h80, 8'hC0};
  logic [15:0]  texp  [8] = '{16'h03FF, 16'hFFC0, 16'h8000, 16'h0100, 16'hAA00, 16'h5500,
                              16'h0000, 16'h7F00};
  int           tcyc  [8] = '{14, 14, 34, 42, 12, 15, 56, 30};

  sarc_conv_ctrl sarc_conv_ctrl_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .timers_i(tmr),
    .external_start_pin_i(pin_i), .cmp_i(cmp_i), .sar_dac_o(sar_dac_o), .track_o(track_o),
    .gain_select_o(gain_select_o), .enable_o(enable_o), .irq_o(irq_o)
  );
  sarc_analog_model sarc_analog_model_inst (
    .sar_dac_i(sar_dac_o), .code_i(code), .cmp_o(cmp_i)
  );

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    // strobe stays up so back-to-back writes never toggle it in one step
    @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_i = a;
    sfr_wr_i   = 1'b0;
    @(negedge clk_i);
    d = sfr_rdata_o;
  endtask : rd

  task automatic chk_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(name, {8'h00, d}, {8'h00, exp});
  endtask : chk_rd

  // launch a conversion from the source of the given start mode
  task automatic fire(input logic [2:0] m, input logic [7:0] ctl);
    if (m != 3'h0) sfr_wr_i = 1'b0;
    case (m)
      3'h0: wr(`SARC_ADDR_CONTROL, ctl | 8'h10);
      3'h1: tmr.t0_ovf = 1'b1;
      3'h2: tmr.t2_low_ovf = 1'b1;
      3'h3: tmr.t1_ovf = 1'b1;
      3'h5: tmr.t3_high_ovf = 1'b1;
      // start pin driven only as the start input
      default: pin_i = 1'b1;
    endcase
    if (m != 3'h0) begin
      @(negedge clk_i);
      tmr = sarc_timers_t'(tmr & 8'h09);
    end
  endtask : fire

  task automatic conv(input logic [7:0] ctl, input logic [15:0] exp, input int ncyc);
    logic [7:0] hi;
    logic [7:0] lo;
    int         c0;
    int         i;
    c0 = cyc;
    // pin start lands three edges after the pin rises
    if (ncyc == 0) repeat (2) @(negedge clk_i);
    rd(`SARC_ADDR_CONTROL, hi);
    chk("busy", {15'h0000, hi[4]}, 16'h0001);
    chk("track", {15'h0000, track_o}, {15'h0000, ctl[6]});
    chk("enable", {15'h0000, enable_o}, {15'h0000, ctl[7]});
    chk("dac msb", {6'h00, sar_dac_o}, 16'h0200);
    i = 0;
    while (irq_o !== 1'b1 && i < 300) begin
      @(negedge clk_i);
      i++;
    end
    if (ncyc != 0) chk("cycles", 16'(cyc - c0), 16'(ncyc));
    chk_rd("control", `SARC_ADDR_CONTROL, ctl | 8'h20);
    rd(`SARC_ADDR_RES_HIGH, hi);
    rd(`SARC_ADDR_RES_LOW, lo);
    chk("result", {hi, lo}, exp);
    wr(`SARC_ADDR_CONTROL, ctl);
    sfr_wr_i = 1'b0;
    @(negedge clk_i);
    chk("flag clear", {15'h0000, irq_o}, 16'h0000);
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 6000);
    err_total++;
    end_sim();
  end

  initial begin
    clk_i       = 1'b0;
    resetn_i    = 1'b0;
    sfr_addr_i  = 8'h00;
    sfr_wr_i    = 1'b0;
    sfr_wdata_i = 8'h00;
    tmr         = sarc_timers_t'(8'h08);
    pin_i       = 1'b0;
    code        = 10'h000;
    err_total   = 0;
    n_tests     = 0;
    cyc         = 0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    chk_rd("config rst", `SARC_ADDR_CONFIG, 8'hF8);
    chk_rd("control rst", `SARC_ADDR_CONTROL, 8'h00);
    chk_rd("high rst", `SARC_ADDR_RES_HIGH, 8'h00);
    chk_rd("low rst", `SARC_ADDR_RES_LOW, 8'h00);
    chk_rd("unmapped", 8'h00, 8'h00);
    for (int k = 0; k < 8; k++) begin
      code = tcode[k];
      wr(`SARC_ADDR_CONFIG, tcfg[k]);
      chk("gain", {15'h0000, gain_select_o}, {15'h0000, tcfg[k][0]});
      // enable and tracking mode must stand before the start write
      wr(`SARC_ADDR_CONTROL, tctl[k]);
      fire(3'h0, tctl[k]);
      conv(tctl[k], texp[k], tcyc[k]);
    end
    // timer 2 in 8-bit mode, timer 3 in 16-bit mode
    wr(`SARC_ADDR_CONFIG, 8'h00);
    code = 10'h155;
    for (int m = 1; m < 6; m++) begin
      wr(`SARC_ADDR_CONTROL, 8'h80 | 8'(m));
      if (m == 2 || m == 5) begin
        sfr_wr_i = 1'b0;
        if (m == 2) tmr.t2_high_ovf = 1'b1;
        else tmr.t3_low_ovf = 1'b1;
        @(negedge clk_i);
        tmr = sarc_timers_t'(tmr & 8'h09);
        repeat (2) @(negedge clk_i);
        chk("wrong overflow", {15'h0000, track_o}, 16'h0001);
      end
      fire(3'(m), 8'h80 | 8'(m));
      conv(8'h80 | 8'(m), 16'h0155, (m == 4) ? 0 : 14);
    end
    wr(`SARC_ADDR_CONTROL, 8'h84);
    chk("pin high track", {15'h0000, track_o}, 16'h0000);
    pin_i    = 1'b0;
    sfr_wr_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("pin low track", {15'h0000, track_o}, 16'h0001);
    wr(`SARC_ADDR_CONTROL, 8'hC4);
    fire(3'h4, 8'hC4);
    conv(8'hC4, 16'h0155, 0);
    chk("delay track", {15'h0000, track_o}, 16'h0001);
    // reserved start mode never triggers; window flag is plain storage
    wr(`SARC_ADDR_CONTROL, 8'h8E);
    wr(`SARC_ADDR_CONTROL, 8'h9E);
    chk_rd("reserved mode", `SARC_ADDR_CONTROL, 8'h8E);
    end_sim();
  end
endmodule : testbench
